// ==== pdpe_pin_mux.v ====
// pin-function multiplexer for port d pins 0..7 and port e pins 0..1
// assumes control bits come from register logic elsewhere, synchronous
// to sys_clk; pad logic resolves level from output and output enable.
// assumes chip-select, serial and can peripheral signals are already
// registered in the sys_clk domain; pad inputs are sampled as they are,
// so any synchroniser for asynchronous pin levels sits outside this block.
`timescale 1ns/1ps
`default_nettype none
`include "pdpe_map.vh"

module pdpe_pin_mux #(
  parameter DW = `PDPE_PORTD_W,
  parameter EW = `PDPE_PORTE_W
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,

  // control registers
  input wire [DW-1:0] portd_periph_enable,
  input wire [7:0] system_pin_select,
  input wire [DW-1:0] portd_pullup_enable,
  input wire [EW-1:0] porte_pullup_enable,
  input wire bus_drive_control,
  input wire ext_bus_active,

  // gpio side
  input wire [DW-1:0] portd_gpio_dir,
  input wire [DW-1:0] portd_gpio_out,
  output reg [DW-1:0] portd_gpio_in_ff,
  input wire [EW-1:0] porte_gpio_dir,
  input wire [EW-1:0] porte_gpio_out,
  output reg [EW-1:0] porte_gpio_in_ff,

  // peripheral sides, chip selects active low
  input wire [5:0] mem_select_n,
  input wire can_ch2_transmit,
  output reg can_ch2_receive_ff,
  input wire serial0_transmit,
  output reg serial0_receive_ff,
  input wire serial1_transmit,
  output reg serial1_receive_ff,

  // port d pads
  input wire [DW-1:0] portd_pad_in,
  output reg [DW-1:0] portd_pad_out_ff,
  output reg [DW-1:0] portd_pad_oe_ff,
  output reg [DW-1:0] portd_pullup_ff,

  // port e pads
  input wire [EW-1:0] porte_pad_in,
  output reg [EW-1:0] porte_pad_out_ff,
  output reg [EW-1:0] porte_pad_oe_ff,
  output reg [EW-1:0] porte_pullup_ff
);

  // -------------------------------------------------------------
  // function selection
  // -------------------------------------------------------------
  // the serial pins have no gpio select here, so their peripheral
  // function is fixed by the reset constant.
  wire [DW-1:0] d_periph;
  wire [EW-1:0] e_periph;
  wire pd0_can;
  wire pd1_can;
  wire cs_drive;

  assign d_periph = portd_periph_enable |
                    (`PDPE_PORTD_PERIPH_RST & {DW{1'b1}});
  assign e_periph = `PDPE_PORTE_PERIPH_RST;
  assign pd0_can = system_pin_select[`PDPE_GPS_PD0_BIT];
  assign pd1_can = system_pin_select[`PDPE_GPS_PD1_BIT];
  // drive-control set releases chip selects while bus is idle
  assign cs_drive = ext_bus_active | ~bus_drive_control;

  // -------------------------------------------------------------
  // port d pad control
  // -------------------------------------------------------------
  reg [DW-1:0] nxt_d_out;
  reg [DW-1:0] nxt_d_oe;

  always @*
  begin
    // gpio default on every pin
    nxt_d_out = portd_gpio_out;
    nxt_d_oe = portd_gpio_dir;
    // pd0: chip select 2 or can transmit
    if (d_periph[0])
    begin
      if (pd0_can)
      begin
        // open drain: drive low only, release for a one
        nxt_d_out[0] = 1'b0;
        nxt_d_oe[0] = ~can_ch2_transmit;
      end
      else
      begin
        nxt_d_out[0] = mem_select_n[0];
        nxt_d_oe[0] = cs_drive;
      end
    end
    // pd1: chip select 3, or can receive with the driver off
    if (d_periph[1])
    begin
      nxt_d_out[1] = mem_select_n[1];
      nxt_d_oe[1] = pd1_can ? 1'b0 : cs_drive;
    end
    // pd6: serial 1 transmit, always driven
    if (d_periph[6])
    begin
      nxt_d_out[6] = serial1_transmit;
      nxt_d_oe[6] = 1'b1;
    end
    // pd7: serial 1 receive, never driven
    if (d_periph[7])
    begin
      nxt_d_out[7] = 1'b0;
      nxt_d_oe[7] = 1'b0;
    end
  end

  // chip selects 4..7 on pd2..pd5, one generate loop
  wire [DW-1:0] d_out_mux;
  wire [DW-1:0] d_oe_mux;
  genvar gi;
  generate
    for (gi = 0; gi < DW; gi = gi + 1)
    begin : g_cs
      if (gi >= 2 && gi <= 5)
      begin : g_sel
        assign d_out_mux[gi] = d_periph[gi] ? mem_select_n[gi] :
                               nxt_d_out[gi];
        assign d_oe_mux[gi] = d_periph[gi] ? cs_drive :
                              nxt_d_oe[gi];
      end
      else
      begin : g_pass
        assign d_out_mux[gi] = nxt_d_out[gi];
        assign d_oe_mux[gi] = nxt_d_oe[gi];
      end
    end
  endgenerate

  // -------------------------------------------------------------
  // pull-up control
  // -------------------------------------------------------------
  // can receive keeps its pull-up whatever the pull-up register says
  wire pd1_can_rx;
  wire [DW-1:0] nxt_d_pu;
  wire [EW-1:0] nxt_e_pu;

  assign pd1_can_rx = d_periph[1] & pd1_can;

  generate
    for (gi = 0; gi < DW; gi = gi + 1)
    begin : g_pu
      if (gi == 1)
      begin : g_can
        assign nxt_d_pu[gi] = portd_pullup_enable[gi] | pd1_can_rx;
      end
      else
      begin : g_plain
        assign nxt_d_pu[gi] = portd_pullup_enable[gi];
      end
    end
  endgenerate

  assign nxt_e_pu = porte_pullup_enable;

  // -------------------------------------------------------------
  // port e pad control
  // -------------------------------------------------------------
  reg [EW-1:0] nxt_e_out;
  reg [EW-1:0] nxt_e_oe;

  always @*
  begin
    nxt_e_out = porte_gpio_out;
    nxt_e_oe = porte_gpio_dir;
    // pe0: serial 0 transmit, always driven
    if (e_periph[0])
    begin
      nxt_e_out[0] = serial0_transmit;
      nxt_e_oe[0] = 1'b1;
    end
    // pe1: serial 0 receive, never driven
    if (e_periph[1])
    begin
      nxt_e_out[1] = 1'b0;
      nxt_e_oe[1] = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // receive routing
  // -------------------------------------------------------------
  // idle-high receive lines when the pin is not routed, so a
  // peripheral never sees a false start bit from a gpio pin
  wire nxt_can_rx;
  wire nxt_s0_rx;
  wire nxt_s1_rx;

  assign nxt_can_rx = pd1_can_rx ? portd_pad_in[1] : 1'b1;
  assign nxt_s0_rx = e_periph[1] ? porte_pad_in[1] : 1'b1;
  assign nxt_s1_rx = d_periph[7] ? portd_pad_in[7] : 1'b1;

  // -------------------------------------------------------------
  // registered port d pads
  // -------------------------------------------------------------
  // in reset every pad is an input with the pull-up on; the serial
  // transmit pin only starts driving once reset is gone
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      portd_pad_out_ff <= {DW{1'b0}};
      portd_pad_oe_ff <= {DW{1'b0}};
      portd_pullup_ff <= `PDPE_PORTD_PULLUP_RST;
    end
    else
    begin
      portd_pad_out_ff <= d_out_mux;
      portd_pad_oe_ff <= d_oe_mux;
      portd_pullup_ff <= nxt_d_pu;
    end
  end

  // -------------------------------------------------------------
  // registered port d readback
  // -------------------------------------------------------------
  // pads read back in any function, one cycle late
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      portd_gpio_in_ff <= {DW{1'b0}};
    end
    else
    begin
      portd_gpio_in_ff <= portd_pad_in;
    end
  end

  // -------------------------------------------------------------
  // registered port e pads
  // -------------------------------------------------------------
  // same reset picture as port d
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      porte_pad_out_ff <= {EW{1'b0}};
      porte_pad_oe_ff <= {EW{1'b0}};
      porte_pullup_ff <= `PDPE_PORTE_PULLUP_RST;
    end
    else
    begin
      porte_pad_out_ff <= nxt_e_out;
      porte_pad_oe_ff <= nxt_e_oe;
      porte_pullup_ff <= nxt_e_pu;
    end
  end

  // -------------------------------------------------------------
  // registered port e readback
  // -------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      porte_gpio_in_ff <= {EW{1'b0}};
    end
    else
    begin
      porte_gpio_in_ff <= porte_pad_in;
    end
  end

  // -------------------------------------------------------------
  // registered receive lines
  // -------------------------------------------------------------
  // idle level in reset so peripherals see a quiet line
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      can_ch2_receive_ff <= 1'b1;
      serial0_receive_ff <= 1'b1;
      serial1_receive_ff <= 1'b1;
    end
    else
    begin
      can_ch2_receive_ff <= nxt_can_rx;
      serial0_receive_ff <= nxt_s0_rx;
      serial1_receive_ff <= nxt_s1_rx;
    end
  end

endmodule
`default_nettype wire

// ==== pdpe_map.vh ====
// pin-function select constants for port d / port e pin group
// assumes inclusion by the single design module pdpe_pin_mux.v
`ifndef PDPE_MAP_VH
`define PDPE_MAP_VH

// port d peripheral enable bits
`define PDPE_PER_CS2_BIT 0
`define PDPE_PER_CS3_BIT 1

// system pin select bits
`define PDPE_GPS_PD0_BIT 4
`define PDPE_GPS_PD1_BIT 5

// widths
`define PDPE_PORTD_W 8
`define PDPE_PORTE_W 2

// reset values: serial pins default to peripheral, others to gpio
`define PDPE_PORTD_PERIPH_RST 8'hc0
`define PDPE_PORTE_PERIPH_RST 2'h3
`define PDPE_PORTD_PULLUP_RST 8'hff
`define PDPE_PORTE_PULLUP_RST 2'h3

`endif

// ==== pdpe_pads.sv ====
// pad model: levels seen at the port pins
// far side may only pull a released pin low
`timescale 1ns/1ps
`default_nettype none
module pdpe_pads #(parameter W = 8) (
  input wire logic clk,
  input wire logic [W-1:0] oe, out, pu, drv,
  output logic [W-1:0] lvl
);
  logic [W-1:0] last_ff;
  always_ff @(posedge clk) last_ff <= lvl;
  // floating pin flips so a stale level never passes as driven
  always_comb
    for (int i = 0; i < W; i++)
      lvl[i] = oe[i] ? out[i] : drv[i] ? 1'b0 : pu[i] | ~last_ff[i];
endmodule
`default_nettype wire

// ==== pdpe_sva.sv ====
// checks on pin mux outputs, one edge after inputs
// bound into pdpe_pin_mux, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module pdpe_sva (
  input wire logic sys_clk, rst, bus_drive_control, ext_bus_active,
  input wire logic can_ch2_transmit, serial1_transmit,
  input wire logic can_ch2_receive_ff, serial1_receive_ff,
  input wire logic [7:0] portd_periph_enable, system_pin_select,
  input wire logic [7:0] portd_pullup_enable, portd_gpio_dir,
  input wire logic [7:0] portd_gpio_out,
  input wire logic [7:0] portd_pad_in, portd_pad_out_ff, portd_pad_oe_ff,
  input wire logic [7:0] portd_pullup_ff,
  input wire logic [5:0] mem_select_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pd0_gpio: assert property (!portd_periph_enable[0] |=>
    portd_pad_oe_ff[0] == $past(portd_gpio_dir[0]) &&
    portd_pad_out_ff[0] == $past(portd_gpio_out[0])) else $error("pd0");
  a_cs_drive: assert property (
    portd_periph_enable[2] && !bus_drive_control |=> portd_pad_oe_ff[2]
    && portd_pad_out_ff[2] == $past(mem_select_n[2])) else $error("cs4");
  a_cs_tristate: assert property (portd_periph_enable[0] &&
    !system_pin_select[4] && bus_drive_control && !ext_bus_active
    |=> !portd_pad_oe_ff[0]) else $error("cs2 idle");
  a_can_tx: assert property (
    portd_periph_enable[0] && system_pin_select[4] |=> !portd_pad_out_ff[0]
    && portd_pad_oe_ff[0] != $past(can_ch2_transmit)) else $error("tx");
  a_can_rx: assert property (
    portd_periph_enable[1] && system_pin_select[5] |=> !portd_pad_oe_ff[1]
    && portd_pullup_ff[1] && can_ch2_receive_ff == $past(portd_pad_in[1]))
    else $error("rx");
  a_pd_pullup: assert property (1'b1 |=>
    portd_pullup_ff[7:2] == $past(portd_pullup_enable[7:2]))
    else $error("pullup");
  a_ser1_tx: assert property (1'b1 |=> portd_pad_oe_ff[6] &&
    portd_pad_out_ff[6] == $past(serial1_transmit)) else $error("s1 tx");
  a_ser1_rx: assert property (1'b1 |=> !portd_pad_oe_ff[7] &&
    serial1_receive_ff == $past(portd_pad_in[7])) else $error("s1 rx");
endmodule
bind pdpe_pin_mux pdpe_sva u_sva (.*);
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the pin mux
// pads come from pdpe_pads, far side pulls pins low on demand
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0, rst = 1'b1;
  logic bus_drive_control = 1'b0, ext_bus_active = 1'b0;
  logic can_ch2_transmit = 1'b1, serial0_transmit = 1'b1;
  logic serial1_transmit = 1'b1;
  logic [7:0] portd_periph_enable = 8'h00, system_pin_select = 8'h00;
  logic [7:0] portd_pullup_enable = 8'hff, portd_gpio_dir = 8'h00;
  logic [7:0] portd_gpio_out = 8'h00, d_drv = 8'h00;
  logic [1:0] porte_pullup_enable = 2'h3, porte_gpio_dir = 2'h0;
  logic [1:0] porte_gpio_out = 2'h0, e_drv = 2'h0;
  logic [5:0] mem_select_n = 6'h3f;
  wire [7:0] portd_gpio_in_ff, portd_pad_in, portd_pad_out_ff;
  wire [7:0] portd_pad_oe_ff, portd_pullup_ff;
  wire [1:0] porte_gpio_in_ff, porte_pad_in, porte_pad_out_ff;
  wire [1:0] porte_pad_oe_ff, porte_pullup_ff;
  wire can_ch2_receive_ff, serial0_receive_ff, serial1_receive_ff;
  int fails = 0, checked = 0, cyc = 0;
  pdpe_pin_mux dut (.*);
  pdpe_pads #(.W(8)) pads_d (.clk(sys_clk), .oe(portd_pad_oe_ff),
    .out(portd_pad_out_ff), .pu(portd_pullup_ff), .drv(d_drv),
    .lvl(portd_pad_in));
  pdpe_pads #(.W(2)) pads_e (.clk(sys_clk), .oe(porte_pad_oe_ff),
    .out(porte_pad_out_ff), .pu(porte_pullup_ff), .drv(e_drv),
    .lvl(porte_pad_in));
  always #4 sys_clk = ~sys_clk;
  task chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // outputs follow inputs one edge later
  task go;
    @(posedge sys_clk);
    #1;
  endtask
  task summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 200)
    begin
      fails++;
      summarize;
    end
  end
  task t_gpio;
    @(posedge sys_clk);
    portd_gpio_dir <= 8'hd5;
    portd_gpio_out <= 8'hff;
    porte_gpio_dir <= 2'h2;
    porte_gpio_out <= 2'h3;
    go;
    chk(portd_pad_oe_ff, 8'h55);
    chk(portd_pad_out_ff & 8'h7f, 8'h7f);
    chk(porte_pad_oe_ff, 8'h01);
    chk(porte_pad_out_ff, 8'h01);
    $display("t_gpio done");
  endtask
  task t_cs;
    @(posedge sys_clk);
    portd_periph_enable <= 8'h3f;
    mem_select_n <= 6'h2a;
    bus_drive_control <= 1'b1;
    go;
    chk(portd_pad_oe_ff, 8'h40);
    @(posedge sys_clk);
    ext_bus_active <= 1'b1;
    go;
    chk(portd_pad_oe_ff, 8'h7f);
    chk(portd_pad_out_ff & 8'h3f, 8'h2a);
    $display("t_cs done");
  endtask
  task t_can;
    @(posedge sys_clk);
    system_pin_select <= 8'h30;
    can_ch2_transmit <= 1'b0;
    portd_pullup_enable <= 8'hfd;
    d_drv <= 8'h02;
    go;
    chk(portd_pad_oe_ff & 8'h03, 8'h01);
    // pd1 pad was still driven as cs3 at the first edge
    go;
    chk({portd_pad_out_ff[0], portd_pullup_ff[1], can_ch2_receive_ff},
      8'h02);
    @(posedge sys_clk);
    can_ch2_transmit <= 1'b1;
    go;
    chk(portd_pad_oe_ff & 8'h01, 8'h00);
    $display("t_can done");
  endtask
  task t_pull;
    @(posedge sys_clk);
    portd_periph_enable <= 8'h00;
    portd_pullup_enable <= 8'h5a;
    porte_pullup_enable <= 2'h2;
    go;
    chk(portd_pullup_ff, 8'h5a);
    chk(porte_pullup_ff, 8'h02);
    go;
    chk(portd_gpio_in_ff & 8'h57, 8'h55);
    chk(porte_gpio_in_ff, 8'h03);
    $display("t_pull done");
  endtask
  task t_ser;
    @(posedge sys_clk);
    serial0_transmit <= 1'b0;
    serial1_transmit <= 1'b0;
    d_drv <= 8'h80;
    e_drv <= 2'h2;
    go;
    chk({porte_pad_out_ff[0], porte_pad_oe_ff, portd_pad_out_ff[6],
      serial0_receive_ff, serial1_receive_ff}, 8'h08);
    $display("t_ser done");
  endtask
  initial
  begin
    repeat (19) @(posedge sys_clk);
    #1;
    chk(portd_pad_oe_ff | porte_pad_oe_ff, 8'h00);
    chk(portd_pullup_ff & {6'h3f, porte_pullup_ff}, 8'hff);
    chk({can_ch2_receive_ff, serial0_receive_ff, serial1_receive_ff},
      8'h07);
    @(posedge sys_clk);
    rst <= 1'b0;
    t_gpio;
    t_cs;
    t_can;
    t_pull;
    t_ser;
    summarize;
  end
endmodule
`default_nettype wire
